/* File: common/tpct_consts.vh */
// register indices, field positions, reset values and timing figures of the timing pins and clock trim block
// assumes the includer places registers at byte address = 4 * index on a 32-bit bus
`ifndef TPCT_CONSTS_VH
`define TPCT_CONSTS_VH

// ***********************************
// register indices (byte address = 4 * index)
// ***********************************
`define TPCT_IDX_INT_STATUS 7'h00
`define TPCT_IDX_INT_MASK 7'h01
`define TPCT_IDX_PIN_OUTPUT_CONTROL 7'h02
`define TPCT_IDX_CLOCK_RATIO_COUNT 7'h0A
`define TPCT_IDX_PIN_SIGNAL_SELECT 7'h0B
`define TPCT_IDX_SLOW_OSC_TRIM 7'h4B
`define TPCT_IDX_FAST_OSC_TRIM 7'h4D
`define TPCT_IDX_SECOND_PIN_DRIVE_ENABLE 7'h4F
`define TPCT_IDX_RATIO_MEASURE_CONTROL 7'h50
`define TPCT_IDX_HOLD_AND_FAST_CLOCK_CONTROL 7'h5F
`define TPCT_IDX_RESULT_FIRST 7'h64
`define TPCT_IDX_RESULT_SECOND 7'h68

// ***********************************
// field positions
// ***********************************
`define TPCT_BIT_SLOT_FIRST_INT 5
`define TPCT_BIT_SLOT_SECOND_INT 6
`define TPCT_BIT_FIRST_POLARITY 0
`define TPCT_BIT_FIRST_OPEN_DRAIN 1
`define TPCT_BIT_FIRST_DRIVE_EN 2
`define TPCT_BIT_SECOND_POLARITY 8
`define TPCT_BIT_SECOND_OPEN_DRAIN 9
`define TPCT_BIT_SECOND_DRIVE_EN 6
`define TPCT_BIT_RATIO_MEASURE_EN 5
`define TPCT_BIT_FAST_OSC_EN 0
`define TPCT_BIT_SLOT_FIRST_FREEZE 1
`define TPCT_BIT_SLOT_SECOND_FREEZE 2
`define TPCT_RATIO_WIDTH 12
`define TPCT_SEL_WIDTH 5

// ***********************************
// reset values
// ***********************************
`define TPCT_RST_INT_MASK 2'h3
`define TPCT_RST_SLOW_TRIM 6'h00
`define TPCT_RST_FAST_TRIM 8'h98

// ***********************************
// pin signal codes
// ***********************************
`define TPCT_SEL_LEGACY 5'h00
`define TPCT_SEL_INTERRUPT 5'h01
`define TPCT_SEL_SAMPLE_WINDOW 5'h02
`define TPCT_SEL_LOGIC0 5'h10
`define TPCT_SEL_LOGIC1 5'h11
`define TPCT_SEL_SLOW_OSC 5'h13

// ***********************************
// timing figures
// ***********************************
`define TPCT_RATIO_SLOW_PERIODS 2'h2
`define TPCT_RATIO_NOMINAL 12'h7D0

`endif

/* File: hw/tpct_timing_pins.v */
// timing pins and clock trim: apb register file, result freeze, oscillator trim and ratio
// measurement, and the two timing output pins
// assumes: slot start/end pulses, slot enables and sample words come from logic on pclk;
// the two oscillator levels come from free-running oscillators and are synchronised here
//
// Notes on behaviour
// RULE1 - a set slot freeze bit blocks updates of that slot's result registers
// RULE2 - clearing a slot freeze bit lets later samples update results again
// RULE3 - host sets freeze, reads results, then clears freeze for coherent data
// RULE4 - slow time base paces sampling, fast time base times internal actions
// RULE5 - six-bit slow trim; larger value lowers slow oscillator frequency
// RULE6 - host calibrates slow clock by comparing pin interrupt rate to set rate
// RULE7 - fast oscillator enable bit turns the fast oscillator on and off
// RULE8 - with ratio enable, count fast cycles over two slow periods, store
// RULE9 - clearing ratio enable resets measurement so re-enable counts afresh
// RULE10 - eight-bit fast trim, reset value 0x98, about 112 kHz per step
// RULE11 - host calibrates fast clock after slow one, from reset trim, iterating
// RULE12 - polarity bits per pin: zero active high, one active low
// RULE13 - drive bits per pin: zero always drives, one drives only when asserted
// RULE14 - first pin drive enabled by bit 2, second by its own register bit 6
// RULE15 - five-bit selectors choose each pin's signal; any signal on either pin
// RULE16 - all-zero selector register gives legacy interrupt and aux pin behaviour
// RULE17 - code 0x01 puts the masked interrupt on the pin
// RULE18 - code 0x02 window spans first enabled slot start to last slot end
// RULE19 - single enabled slot: window spans just that slot
// RULE20 - unheld slot results all update together at the slot's end
// RULE21 - interrupt mask bits 5 and 6 gate slot sample interrupts; zero enables
// RULE22 - a sample ending during freeze is dropped; next sample after release lands
`timescale 1ns/10ps
`include "tpct_consts.vh"

module tpct_timing_pins #(
  parameter CHANNELS = 4,
  parameter DATA_WIDTH = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire slot_first_enabled,
  input wire slot_second_enabled,
  input wire slot_first_start,
  input wire slot_first_end,
  input wire slot_second_start,
  input wire slot_second_end,
  input wire [CHANNELS*DATA_WIDTH-1:0] slot_first_sample,
  input wire [CHANNELS*DATA_WIDTH-1:0] slot_second_sample,
  input wire slow_osc_level,
  input wire fast_osc_level,
  output reg [5:0] slow_osc_trim_field,
  output reg [7:0] fast_osc_trim_field,
  output reg fast_osc_enable,
  output reg first_timing_pin_out,
  output reg first_timing_pin_oe,
  output reg second_timing_pin_out,
  output reg second_timing_pin_oe
);

  // ***********************************
  // configuration registers
  // ***********************************
  reg [1:0] int_status;
  reg [1:0] int_mask;
  reg first_polarity;
  reg first_open_drain;
  reg first_drive_en;
  reg second_polarity;
  reg second_open_drain;
  reg second_drive_en;
  reg [4:0] first_sel;
  reg [4:0] second_sel;
  reg ratio_measure_enable;
  reg slot_first_freeze;
  reg slot_second_freeze;
  reg [DATA_WIDTH-1:0] result_first [0:CHANNELS-1];
  reg [DATA_WIDTH-1:0] result_second [0:CHANNELS-1];
  reg [11:0] ratio_count;
  reg sample_window;

  wire [6:0] index;
  wire access;
  wire wr_commit;
  wire first_update;
  wire second_update;
  wire interrupt_line;
  reg mapped;
  reg [15:0] read_value;
  integer ch;

  assign index = paddr[8:2];
  assign access = psel & penable;
  // writes land only at the edge where the master sees pready high
  assign wr_commit = access & pready & pwrite & mapped;
  assign first_update = slot_first_end & ~slot_first_freeze; // RULE1 RULE22
  assign second_update = slot_second_end & ~slot_second_freeze; // RULE1 RULE22
  assign interrupt_line = |(int_status & ~int_mask); // RULE21

  // ***********************************
  // address decode and read mux
  // ***********************************
  always @*
  begin
    mapped = 1'b1;
    read_value = 16'h0000;
    if (index == `TPCT_IDX_INT_STATUS)
    begin
      read_value[`TPCT_BIT_SLOT_SECOND_INT:`TPCT_BIT_SLOT_FIRST_INT] = int_status;
    end
    else if (index == `TPCT_IDX_INT_MASK)
    begin
      read_value[`TPCT_BIT_SLOT_SECOND_INT:`TPCT_BIT_SLOT_FIRST_INT] = int_mask;
    end
    else if (index == `TPCT_IDX_PIN_OUTPUT_CONTROL)
    begin
      read_value[`TPCT_BIT_FIRST_POLARITY] = first_polarity;
      read_value[`TPCT_BIT_FIRST_OPEN_DRAIN] = first_open_drain;
      read_value[`TPCT_BIT_FIRST_DRIVE_EN] = first_drive_en;
      read_value[`TPCT_BIT_SECOND_POLARITY] = second_polarity;
      read_value[`TPCT_BIT_SECOND_OPEN_DRAIN] = second_open_drain;
    end
    else if (index == `TPCT_IDX_CLOCK_RATIO_COUNT)
    begin
      read_value[11:0] = ratio_count;
    end
    else if (index == `TPCT_IDX_PIN_SIGNAL_SELECT)
    begin
      read_value[12:8] = second_sel;
      read_value[4:0] = first_sel;
    end
    else if (index == `TPCT_IDX_SLOW_OSC_TRIM)
    begin
      read_value[5:0] = slow_osc_trim_field;
    end
    else if (index == `TPCT_IDX_FAST_OSC_TRIM)
    begin
      read_value[7:0] = fast_osc_trim_field;
    end
    else if (index == `TPCT_IDX_SECOND_PIN_DRIVE_ENABLE)
    begin
      read_value[`TPCT_BIT_SECOND_DRIVE_EN] = second_drive_en;
    end
    else if (index == `TPCT_IDX_RATIO_MEASURE_CONTROL)
    begin
      read_value[`TPCT_BIT_RATIO_MEASURE_EN] = ratio_measure_enable;
    end
    else if (index == `TPCT_IDX_HOLD_AND_FAST_CLOCK_CONTROL)
    begin
      read_value[`TPCT_BIT_FAST_OSC_EN] = fast_osc_enable;
      read_value[`TPCT_BIT_SLOT_FIRST_FREEZE] = slot_first_freeze;
      read_value[`TPCT_BIT_SLOT_SECOND_FREEZE] = slot_second_freeze;
    end
    else if (index >= `TPCT_IDX_RESULT_FIRST && index < `TPCT_IDX_RESULT_FIRST + CHANNELS)
    begin
      read_value = result_first[index[1:0]];
    end
    else if (index >= `TPCT_IDX_RESULT_SECOND && index < `TPCT_IDX_RESULT_SECOND + CHANNELS)
    begin
      read_value = result_second[index[1:0]];
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // ***********************************
  // apb handshake: one wait state so that every answer leaves a flip-flop
  // ***********************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access & ~pready & ~pwrite)
      begin
        prdata <= {16'h0, read_value};
      end
    end
  end

  // ***********************************
  // register writes
  // ***********************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_mask <= `TPCT_RST_INT_MASK;
      first_polarity <= 1'b0;
      first_open_drain <= 1'b0;
      first_drive_en <= 1'b0;
      second_polarity <= 1'b0;
      second_open_drain <= 1'b0;
      second_drive_en <= 1'b0;
      first_sel <= `TPCT_SEL_LEGACY;
      second_sel <= `TPCT_SEL_LEGACY;
      slow_osc_trim_field <= `TPCT_RST_SLOW_TRIM;
      fast_osc_trim_field <= `TPCT_RST_FAST_TRIM;
      ratio_measure_enable <= 1'b0;
      fast_osc_enable <= 1'b0;
      slot_first_freeze <= 1'b0;
      slot_second_freeze <= 1'b0;
    end
    else if (wr_commit)
    begin
      if (index == `TPCT_IDX_INT_MASK)
      begin
        int_mask <= pwdata[`TPCT_BIT_SLOT_SECOND_INT:`TPCT_BIT_SLOT_FIRST_INT]; // RULE21
      end
      else if (index == `TPCT_IDX_PIN_OUTPUT_CONTROL)
      begin
        first_polarity <= pwdata[`TPCT_BIT_FIRST_POLARITY]; // RULE12
        first_open_drain <= pwdata[`TPCT_BIT_FIRST_OPEN_DRAIN]; // RULE13
        first_drive_en <= pwdata[`TPCT_BIT_FIRST_DRIVE_EN]; // RULE14
        second_polarity <= pwdata[`TPCT_BIT_SECOND_POLARITY]; // RULE12
        second_open_drain <= pwdata[`TPCT_BIT_SECOND_OPEN_DRAIN]; // RULE13
      end
      else if (index == `TPCT_IDX_PIN_SIGNAL_SELECT)
      begin
        second_sel <= pwdata[12:8]; // RULE15
        first_sel <= pwdata[4:0]; // RULE15
      end
      else if (index == `TPCT_IDX_SLOW_OSC_TRIM)
      begin
        // the oscillator runs slower as the code rises
        slow_osc_trim_field <= pwdata[5:0]; // RULE5
      end
      else if (index == `TPCT_IDX_FAST_OSC_TRIM)
      begin
        fast_osc_trim_field <= pwdata[7:0]; // RULE10
      end
      else if (index == `TPCT_IDX_SECOND_PIN_DRIVE_ENABLE)
      begin
        second_drive_en <= pwdata[`TPCT_BIT_SECOND_DRIVE_EN]; // RULE14
      end
      else if (index == `TPCT_IDX_RATIO_MEASURE_CONTROL)
      begin
        ratio_measure_enable <= pwdata[`TPCT_BIT_RATIO_MEASURE_EN]; // RULE8 RULE9
      end
      else if (index == `TPCT_IDX_HOLD_AND_FAST_CLOCK_CONTROL)
      begin
        fast_osc_enable <= pwdata[`TPCT_BIT_FAST_OSC_EN]; // RULE7
        slot_first_freeze <= pwdata[`TPCT_BIT_SLOT_FIRST_FREEZE]; // RULE1 RULE2
        slot_second_freeze <= pwdata[`TPCT_BIT_SLOT_SECOND_FREEZE]; // RULE1 RULE2
      end
    end
  end

  // ***********************************
  // sticky sample flags: a new sample beats a write-one clear in the same cycle
  // ***********************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_status <= 2'h0;
    end
    else
    begin
      if (first_update)
      begin
        int_status[0] <= 1'b1;
      end
      else if (wr_commit && index == `TPCT_IDX_INT_STATUS && pwdata[`TPCT_BIT_SLOT_FIRST_INT])
      begin
        int_status[0] <= 1'b0;
      end
      if (second_update)
      begin
        int_status[1] <= 1'b1;
      end
      else if (wr_commit && index == `TPCT_IDX_INT_STATUS && pwdata[`TPCT_BIT_SLOT_SECOND_INT])
      begin
        int_status[1] <= 1'b0;
      end
    end
  end

  // ***********************************
  // result registers: all channels of a slot move in the same edge
  // ***********************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (ch = 0; ch < CHANNELS; ch = ch + 1)
      begin
        result_first[ch] <= {DATA_WIDTH{1'b0}};
        result_second[ch] <= {DATA_WIDTH{1'b0}};
      end
    end
    else
    begin
      for (ch = 0; ch < CHANNELS; ch = ch + 1)
      begin
        if (first_update)
        begin
          result_first[ch] <= slot_first_sample[ch*DATA_WIDTH +: DATA_WIDTH]; // RULE20 RULE2
        end
        if (second_update)
        begin
          result_second[ch] <= slot_second_sample[ch*DATA_WIDTH +: DATA_WIDTH]; // RULE20 RULE2
        end
      end
    end
  end

  // ***********************************
  // oscillator synchronisers and ratio measurement
  // ***********************************
  reg slow_meta;
  reg slow_sync;
  reg slow_prev;
  reg fast_meta;
  reg fast_sync;
  reg fast_prev;
  reg [1:0] slow_edges;
  reg [11:0] fast_edges;
  reg ratio_armed;
  reg ratio_done;
  wire slow_rise;
  wire fast_rise;

  assign slow_rise = slow_sync & ~slow_prev;
  assign fast_rise = fast_sync & ~fast_prev;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_prev <= 1'b0;
      fast_meta <= 1'b0;
      fast_sync <= 1'b0;
      fast_prev <= 1'b0;
    end
    else
    begin
      slow_meta <= slow_osc_level;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
      fast_meta <= fast_osc_level;
      fast_sync <= fast_meta;
      fast_prev <= fast_sync;
    end
  end

  // a single measurement per enable; fast_edges saturates at 0xFFF, but a fast rise on the closing slow edge then wraps ratio_count to 0
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_edges <= 2'h0;
      fast_edges <= 12'h0;
      ratio_armed <= 1'b0;
      ratio_done <= 1'b0;
      ratio_count <= 12'h0;
    end
    else if (!ratio_measure_enable)
    begin
      slow_edges <= 2'h0; // RULE9
      fast_edges <= 12'h0; // RULE9
      ratio_armed <= 1'b0; // RULE9
      ratio_done <= 1'b0; // RULE9
    end
    else if (!ratio_done && slow_rise)
    begin
      if (!ratio_armed)
      begin
        ratio_armed <= 1'b1;
      end
      else if (slow_edges + 2'h1 == `TPCT_RATIO_SLOW_PERIODS)
      begin
        ratio_count <= fast_edges + {11'h0, fast_rise}; // RULE8 RULE4
        ratio_done <= 1'b1;
      end
      else
      begin
        slow_edges <= slow_edges + 2'h1;
      end
      if (ratio_armed && fast_rise && fast_edges != 12'hFFF)
      begin
        fast_edges <= fast_edges + 12'h001;
      end
    end
    else if (!ratio_done && ratio_armed && fast_rise && fast_edges != 12'hFFF)
    begin
      fast_edges <= fast_edges + 12'h001; // RULE8 RULE4
    end
  end

  // ***********************************
  // sample window
  // ***********************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_window <= 1'b0;
    end
    else if ((slot_first_enabled & slot_first_start) |
             (~slot_first_enabled & slot_second_enabled & slot_second_start))
    begin
      sample_window <= 1'b1; // RULE18 RULE19
    end
    else if ((slot_second_enabled & slot_second_end) |
             (~slot_second_enabled & slot_first_enabled & slot_first_end))
    begin
      sample_window <= 1'b0; // RULE18 RULE19
    end
  end

  // ***********************************
  // pin signal selection and drive
  // ***********************************
  function pick_signal;
    input [4:0] code;
    input legacy_value;
    begin
      if (code == `TPCT_SEL_INTERRUPT)
        pick_signal = interrupt_line; // RULE17
      else if (code == `TPCT_SEL_SAMPLE_WINDOW)
        pick_signal = sample_window; // RULE18
      else if (code == `TPCT_SEL_LOGIC1)
        pick_signal = 1'b1;
      else if (code == `TPCT_SEL_SLOW_OSC)
        pick_signal = slow_sync;
      else if (code == `TPCT_SEL_LEGACY)
        pick_signal = legacy_value;
      else
        pick_signal = 1'b0;
    end
  endfunction

  wire legacy_mode;
  wire first_asserted;
  wire second_asserted;

  // legacy applies only when the whole selector register is zero
  assign legacy_mode = (first_sel == `TPCT_SEL_LEGACY) && (second_sel == `TPCT_SEL_LEGACY); // RULE16
  assign first_asserted = legacy_mode ? interrupt_line : pick_signal(first_sel, 1'b0); // RULE15 RULE16
  assign second_asserted = legacy_mode ? sample_window : pick_signal(second_sel, 1'b0); // RULE15 RULE16

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_timing_pin_out <= 1'b0;
      first_timing_pin_oe <= 1'b0;
      second_timing_pin_out <= 1'b0;
      second_timing_pin_oe <= 1'b0;
    end
    else
    begin
      first_timing_pin_out <= first_asserted ^ first_polarity; // RULE12
      first_timing_pin_oe <= first_drive_en & (~first_open_drain | first_asserted); // RULE13 RULE14
      second_timing_pin_out <= second_asserted ^ second_polarity; // RULE12
      second_timing_pin_oe <= second_drive_en & (~second_open_drain | second_asserted); // RULE13 RULE14
    end
  end

endmodule // tpct_timing_pins

/* File: verif/tpct_far_model.sv */
// far-side model: slot timing source, sample words and the two oscillators
// assumes one pclk domain; oscillator levels outlast the synchroniser
`timescale 1ns/10ps
module tpct_far_model (
  input wire pclk,
  input wire presetn,
  input wire go,
  input wire en_a,
  input wire en_b,
  input wire fast_osc_enable,
  output reg a_start,
  output reg a_end,
  output reg b_start,
  output reg b_end,
  output wire [63:0] a_smp,
  output wire [63:0] b_smp,
  output reg slow_lvl,
  output reg fast_lvl
);
  // ********************
  // slot sequencer and oscillators
  // ********************
  reg [3:0] ph;
  reg [15:0] seq;
  reg [8:0] cnt;
  assign a_smp = {4{seq}};
  assign b_smp = {4{~seq}};
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph <= 4'h0;
      seq <= 16'hA5C0;
      cnt <= 9'h0;
      a_start <= 1'b0;
      a_end <= 1'b0;
      b_start <= 1'b0;
      b_end <= 1'b0;
      slow_lvl <= 1'b0;
      fast_lvl <= 1'b0;
    end
    else
    begin
      a_start <= en_a && ph == 4'h1;
      a_end <= en_a && ph == 4'h4;
      b_start <= en_b && ph == 4'h5;
      b_end <= en_b && ph == 4'h8;
      ph <= go ? 4'h1 : (ph == 4'h0 || ph == 4'h9) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h9)
        seq <= seq + 16'h1;
      cnt <= (cnt == 9'h18F) ? 9'h0 : cnt + 9'h1;
      // slow period 400, fast 8: 100 fast rises per two slow periods
      slow_lvl <= cnt < 9'h0C8;
      fast_lvl <= fast_osc_enable && cnt[2];
    end
endmodule // tpct_far_model

/* File: verif/tpct_checker_assertions.sv */
// checker for the timing pins block: apb handshake and pin drive relations
// assumes binding into tpct_timing_pins, byte address 4 * index
`timescale 1ns/10ps
module tpct_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire first_timing_pin_out,
  input wire first_timing_pin_oe,
  input wire second_timing_pin_out,
  input wire second_timing_pin_oe
);
  // ********************
  // config shadow, one edge late like the registered pins
  // ********************
  reg [15:0] ctl;
  reg [15:0] ctl_d;
  reg [15:0] sel;
  reg [15:0] sel_d;
  reg drv2;
  reg drv2_d;
  wire wr_done = psel && penable && pready && pwrite;
  wire [6:0] idx = paddr[8:2];
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctl <= 16'h0;
      ctl_d <= 16'h0;
      sel <= 16'h0;
      sel_d <= 16'h0;
      drv2 <= 1'b0;
      drv2_d <= 1'b0;
    end
    else
    begin
      if (wr_done && idx == 7'h02)
        ctl <= pwdata[15:0];
      if (wr_done && idx == 7'h0B)
        sel <= pwdata[15:0];
      if (wr_done && idx == 7'h4F)
        drv2 <= pwdata[6];
      ctl_d <= ctl;
      sel_d <= sel;
      drv2_d <= drv2;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********************
  // assertions
  // ********************
  wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("access not answered");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  err_mapped_a: assert property (pready && idx inside {7'h02, 7'h0B, 7'h4B, 7'h4D, 7'h4F, 7'h50, 7'h5F}
    |-> !pslverr) else $error("error on mapped register");
  read_upper_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
  first_oe_off_a: assert property (!ctl_d[2] |-> !first_timing_pin_oe) else $error("first pin drives");
  second_oe_off_a: assert property (!drv2_d |-> !second_timing_pin_oe) else $error("second pin drives");
  first_drain_a: assert property (ctl_d[2] && ctl_d[1] |-> first_timing_pin_oe ==
    (first_timing_pin_out ^ ctl_d[0])) else $error("open drain enable wrong");
  first_push_a: assert property (ctl_d[2] && !ctl_d[1] |-> first_timing_pin_oe) else $error("push pull off");
  second_high_a: assert property (sel_d[12:8] == 5'h11 |-> second_timing_pin_out != ctl_d[8])
    else $error("logic one code wrong");
  first_low_a: assert property (sel_d[4:0] == 5'h10 |-> first_timing_pin_out == ctl_d[0])
    else $error("logic zero code wrong");
  cover property (pslverr);
  cover property (ctl_d[2] && ctl_d[1] && first_timing_pin_oe);
  cover property (sel_d[12:8] == 5'h02 && second_timing_pin_out);
endmodule // tpct_checker

bind tpct_timing_pins tpct_checker tpct_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .first_timing_pin_out(first_timing_pin_out), .first_timing_pin_oe(first_timing_pin_oe),
  .second_timing_pin_out(second_timing_pin_out), .second_timing_pin_oe(second_timing_pin_oe));

/* File: verif/tpct_timing_pins_bench.sv */
// self-checking bench for the timing pins block
// assumes registers at byte address 4 * index and an apb answer within 20 cycles
`timescale 1ns/10ps
module tpct_timing_pins_bench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [9:0] paddr = 10'h0;
  reg [31:0] pwdata = 32'h0;
  reg go = 1'b0;
  reg en_a = 1'b0;
  reg en_b = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, a_start, a_end, b_start, b_end, slow_lvl, fast_lvl, fen, p1, p1oe, p2, p2oe;
  wire [63:0] a_smp, b_smp;
  wire [5:0] strim;
  wire [7:0] ftrim;
  reg [31:0] rdat;
  reg rerr;
  integer bad_count, checks_done, hi1, hi2;
  always #10 pclk = ~pclk;
  tpct_timing_pins tpct_timing_pins_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_first_enabled(en_a), .slot_second_enabled(en_b), .slot_first_start(a_start),
    .slot_first_end(a_end), .slot_second_start(b_start), .slot_second_end(b_end),
    .slot_first_sample(a_smp), .slot_second_sample(b_smp), .slow_osc_level(slow_lvl),
    .fast_osc_level(fast_lvl), .slow_osc_trim_field(strim), .fast_osc_trim_field(ftrim),
    .fast_osc_enable(fen), .first_timing_pin_out(p1), .first_timing_pin_oe(p1oe),
    .second_timing_pin_out(p2), .second_timing_pin_oe(p2oe));
  tpct_far_model tpct_far_model_i (.pclk(pclk), .presetn(presetn), .go(go), .en_a(en_a), .en_b(en_b),
    .fast_osc_enable(fen), .a_start(a_start), .a_end(a_end), .b_start(b_start), .b_end(b_end),
    .a_smp(a_smp), .b_smp(b_smp), .slow_lvl(slow_lvl), .fast_lvl(fast_lvl));
  // ********************
  // shared tasks
  // ********************
  task wrap_up;
    begin
      if (bad_count == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
    end
  endtask
  // one idle edge after each transfer
  task apb(input wr, input [6:0] idx, input [31:0] wd);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {1'b0, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
        bad_count = bad_count + 1;
        wrap_up;
      end
      @(posedge pclk);
    end
  endtask
  task wr(input [6:0] i, input [31:0] d);
    apb(1'b1, i, d);
  endtask
  task rd(input [6:0] i);
    apb(1'b0, i, 32'h0);
  endtask
  function [15:0] sq(input integer k);
    sq = 16'hA5C0 + k[15:0];
  endfunction
  // one far-side sample; counts high cycles per pin
  task run(input a, input b);
    integer k;
    begin
      en_a <= a;
      en_b <= b;
      go <= 1'b1;
      hi1 = 0;
      hi2 = 0;
      @(posedge pclk);
      go <= 1'b0;
      for (k = 0; k < 16; k = k + 1)
      begin
        @(posedge pclk);
        #1;
        hi1 = hi1 + p1;
        hi2 = hi2 + p2;
      end
      @(posedge pclk);
    end
  endtask
  task pinchk(input [3:0] e);
    begin
      @(posedge pclk);
      #1;
      chk({28'h0, e}, {28'h0, p1, p1oe, p2, p2oe});
      @(posedge pclk);
    end
  endtask
  // ********************
  // scenarios
  // ********************
  task t_regs;
    begin
      chk(32'h98, {24'h0, ftrim});
      rd(7'h4D);
      chk(32'h98, rdat);
      rd(7'h03);
      chk(32'h1, {31'h0, rerr});
      chk(32'h0, rdat);
      wr(7'h4B, 32'hFFFF);
      rd(7'h4B);
      chk(32'h3F, rdat);
      chk(32'h3F, {26'h0, strim});
      wr(7'h4D, 32'h5C);
      rd(7'h4D);
      chk(32'h5C, {24'h0, ftrim});
    end
  endtask
  task t_ratio;
    begin
      wr(7'h50, 32'h20);
      repeat (1300) @(posedge pclk);
      rd(7'h0A);
      chk(32'h0, rdat);
      wr(7'h50, 32'h0);
      wr(7'h5F, 32'h1);
      rd(7'h5F);
      chk(32'h1, {31'h0, fen});
      wr(7'h50, 32'h20);
      repeat (1300) @(posedge pclk);
      wr(7'h0A, 32'hFFF);
      rd(7'h0A);
      chk(32'h64, rdat);
      wr(7'h5F, 32'h0);
      rd(7'h5F);
      chk(32'h0, {31'h0, fen});
    end
  endtask
  task t_freeze;
    begin
      run(1'b1, 1'b1);
      rd(7'h64);
      chk({16'h0, sq(0)}, rdat);
      rd(7'h6B);
      chk({16'h0, ~sq(0)}, rdat);
      wr(7'h5F, 32'h2);
      run(1'b1, 1'b1);
      rd(7'h67);
      chk({16'h0, sq(0)}, rdat);
      rd(7'h68);
      chk({16'h0, ~sq(1)}, rdat);
      wr(7'h5F, 32'h0);
      rd(7'h65);
      chk({16'h0, sq(0)}, rdat);
      run(1'b1, 1'b1);
      rd(7'h66);
      chk({16'h0, sq(2)}, rdat);
      wr(7'h5F, 32'h4);
      run(1'b0, 1'b1);
      rd(7'h69);
      chk({16'h0, ~sq(2)}, rdat);
      wr(7'h5F, 32'h0);
    end
  endtask
  task t_pins;
    begin
      wr(7'h0B, 32'h1110);
      wr(7'h02, 32'h4);
      wr(7'h4F, 32'h40);
      pinchk(4'h7);
      wr(7'h02, 32'h305);
      pinchk(4'hD);
      wr(7'h02, 32'h6);
      pinchk(4'h3);
      wr(7'h4F, 32'h0);
      pinchk(4'h2);
    end
  endtask
  task t_window;
    begin
      wr(7'h0B, 32'h0);
      wr(7'h02, 32'h4);
      wr(7'h4F, 32'h40);
      run(1'b1, 1'b1);
      chk(32'h7, hi2);
      chk(32'h0, hi1);
      wr(7'h0B, 32'h200);
      run(1'b0, 1'b1);
      chk(32'h3, hi2);
      run(1'b1, 1'b0);
      chk(32'h3, hi2);
    end
  endtask
  task t_irq;
    begin
      wr(7'h00, 32'h60);
      wr(7'h0B, 32'h1);
      wr(7'h01, 32'h40);
      run(1'b0, 1'b1);
      chk(32'h0, hi1);
      run(1'b1, 1'b0);
      rd(7'h00);
      chk(32'h60, rdat);
      pinchk(4'hD);
      wr(7'h00, 32'h20);
      pinchk(4'h5);
    end
  endtask
  initial
  begin
    bad_count = 0;
    checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_ratio;
    t_freeze;
    t_pins;
    t_window;
    t_irq;
    wrap_up;
  end
endmodule // tpct_timing_pins_bench
